// ===== verilog/rip_cfg.svh
// Offsets, field positions and reset values for the reset and interrupt pin block
`ifndef RIP_CFG_SVH
`define RIP_CFG_SVH
`define RIP_ADDR_CTRL    12'h000
`define RIP_ADDR_STATUS  12'h004
`define RIP_ADDR_MASK    12'h008
`define RIP_ADDR_EDGE    12'h00c
`define RIP_ADDR_PINS    12'h010
`define RIP_CTRL_IRQ_EDGE   0
`define RIP_CTRL_X_FLAG     1
`define RIP_CTRL_I_FLAG     2
`define RIP_CTRL_SINGLE     3
`define RIP_CTRL_RESET      4'he
`define RIP_NPIN            5
`define RIP_ZERO5           5'h00
`define RIP_EDGE_RESET      10'h000
`define RIP_EDGE_RISE       2'h1
`define RIP_EDGE_FALL       2'h2
`define RIP_EDGE_BOTH       2'h3
`define RIP_STROBE_A_INPUT_BIT        4
`define RIP_PAI_BIT         3
`endif

// ===== verilog/rip_pkg.sv
// Types for the reset and interrupt pin block
package rip_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rip_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rip_apb_rsp_type;

  typedef enum logic [2:0] {
    RIP_RUN   = 3'h1,
    RIP_FAULT = 3'h2,
    RIP_HOLD  = 3'h4
  } rip_rst_state_type;

  typedef struct packed {
    logic [4:0]        pin_s1;
    logic [4:0]        pin_s2;
    logic [4:0]        pin_old;
    logic [1:0]        irq_s;
    logic [1:0]        nonmaskable_request_pin_s;
    logic              irq_old;
    logic [1:0]        rst_s;
    logic [3:0]        ctrl;
    logic [4:0]        status;
    logic [4:0]        mask;
    logic [9:0]        edge_sel;
    logic              irq_pend;
    logic [31:0]       rdata;
    rip_rst_state_type rst_state;
  } rip_state_type;
endpackage : rip_pkg

// ===== verilog/rip_top.sv
// Reset pin, dedicated request pins and five peripheral pin interrupts
`timescale 1ns/1ps
`include "rip_cfg.svh"

// Register map, one 32-bit word each:
//   ctrl    bit 0 maskable line falling-edge mode; a write clears the edge latch
//   ctrl    bit 1 nonmaskable mask flag, set by reset
//   ctrl    bit 2 maskable mask flag, set by reset
//   ctrl    bit 3 single-chip mode; low hands the strobe pin to the address strobe
//   status  bits 4:0 sticky pin events, write one to clear; an event beats a clear
//   mask    bits 4:0 local enables of the five pin interrupts
//   edge    two bits per pin: rise, fall or both; accumulator and strobe read both as rise
//   pins    bits 7:0 synchronised reset, nonmaskable, maskable and five pin levels
// Pin order in every five-bit field: capture 3, capture 2, capture 1, accumulator, strobe.
// Limitation: pins pass two flip-flops, so an event reaches status three clocks late.

module rip_top (
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     ce_i,
  input  wire rip_pkg::rip_apb_req_type apb_req_i,
  output rip_pkg::rip_apb_rsp_type      apb_rsp_o,
  input  wire logic                     reset_pin_i,
  output logic                          reset_pin_o,
  output logic                          reset_pin_oe_o,
  input  wire logic                     clock_fail_i,
  input  wire logic                     watchdog_fail_i,
  input  wire logic                     nonmaskable_request_pin_i,
  input  wire logic                     irq_pin_i,
  input  wire logic                     capture_input_1_i,
  input  wire logic                     capture_input_2_i,
  input  wire logic                     capture_input_3_i,
  input  wire logic                     pulse_accumulator_input_i,
  input  wire logic                     strobe_a_input_i,
  input  wire logic                     address_strobe_i,
  output logic                          address_strobe_output_o,
  output logic                          logic_reset_o,
  output logic                          nonmaskable_request_pin_int_o,
  output logic                          irq_int_o,
  output logic                          pin_int_o,
  output logic                          int_o
);
  import rip_pkg::*;

  rip_state_type q;
  rip_state_type d;
  logic [4:0]    pins;
  logic [4:0]    rise;
  logic [4:0]    fall;
  logic [4:0]    hit;
  logic          acc;
  logic          wr;
  logic          rd;
  logic          irq_edge_ev;
  logic          wr_ctrl;
  logic          wr_status;
  logic          wr_mask;
  logic          wr_edge;

  // Pin order: capture 3,2,1, accumulator, strobe A
  assign pins = {strobe_a_input_i, pulse_accumulator_input_i,
                 capture_input_1_i, capture_input_2_i, capture_input_3_i};

  assign acc = apb_req_i.psel & apb_req_i.penable;
  assign wr  = acc & apb_req_i.pwrite;
  assign rd  = acc & ~apb_req_i.pwrite;

  // Register write strokes, named for the checks below
  assign wr_ctrl   = wr & (apb_req_i.paddr == `RIP_ADDR_CTRL);
  assign wr_status = wr & (apb_req_i.paddr == `RIP_ADDR_STATUS);
  assign wr_mask   = wr & (apb_req_i.paddr == `RIP_ADDR_MASK);
  assign wr_edge   = wr & (apb_req_i.paddr == `RIP_ADDR_EDGE);

  // Edge detect on second synchroniser stage only
  assign rise = q.pin_s2 & ~q.pin_old;
  assign fall = ~q.pin_s2 & q.pin_old;

  // Per-pin edge qualification
  genvar g;
  generate
    for (g = 0; g < `RIP_NPIN; g = g + 1) begin : g_edge
      logic [1:0] sel;
      logic       ok;
      // Accumulator and strobe never see both edges; both falls back to rise
      assign sel = (g >= `RIP_PAI_BIT && q.edge_sel[2*g +: 2] == `RIP_EDGE_BOTH)
                   ? `RIP_EDGE_RISE : q.edge_sel[2*g +: 2];
      // Strobe pin is address strobe in expanded modes
      assign ok  = (g != `RIP_STROBE_A_INPUT_BIT) || q.ctrl[`RIP_CTRL_SINGLE];
      assign hit[g] = ok & ((sel[0] & rise[g]) | (sel[1] & fall[g]));
    end
  endgenerate

  assign irq_edge_ev = q.irq_old & ~q.irq_s[1];

  // Next state
  always_comb begin
    d = q;
    d.pin_s1  = pins;
    d.pin_s2  = q.pin_s1;
    d.pin_old = q.pin_s2;
    d.irq_s   = {q.irq_s[0], irq_pin_i};
    d.nonmaskable_request_pin_s  = {q.nonmaskable_request_pin_s[0], nonmaskable_request_pin_i};
    d.irq_old = q.irq_s[1];
    d.rst_s   = {q.rst_s[0], reset_pin_i};
    // Events set sticky flags; set wins over a write-one clear
    d.status  = q.status & ~(wr && apb_req_i.paddr == `RIP_ADDR_STATUS
                ? apb_req_i.pwdata[4:0] : `RIP_ZERO5);
    d.status  = d.status | hit;
    // Edge mode latch for the maskable pin, cleared by writing ctrl
    if (wr && apb_req_i.paddr == `RIP_ADDR_CTRL) begin
      d.ctrl = apb_req_i.pwdata[3:0];
      d.irq_pend = 1'b0;
    end
    if (irq_edge_ev) begin
      d.irq_pend = 1'b1;
    end
    if (wr && apb_req_i.paddr == `RIP_ADDR_MASK) begin
      d.mask = apb_req_i.pwdata[4:0];
    end
    if (wr && apb_req_i.paddr == `RIP_ADDR_EDGE) begin
      d.edge_sel = apb_req_i.pwdata[9:0];
    end
    // Read data registered one cycle early so it is stable at the access edge
    d.rdata = 32'h0000_0000;
    unique case (apb_req_i.paddr)
      `RIP_ADDR_CTRL:   d.rdata[3:0] = q.ctrl;
      `RIP_ADDR_STATUS: d.rdata[4:0] = q.status;
      `RIP_ADDR_MASK:   d.rdata[4:0] = q.mask;
      `RIP_ADDR_EDGE:   d.rdata[9:0] = q.edge_sel;
      `RIP_ADDR_PINS:   d.rdata[7:0] = {q.rst_s[1], q.nonmaskable_request_pin_s[1], q.irq_s[1], q.pin_s2};
      default:          d.rdata = 32'h0000_0000;
    endcase
    // Failure latches the pin low until the pin is seen low and the failure has cleared
    unique case (q.rst_state)
      RIP_RUN:   if (clock_fail_i | watchdog_fail_i) d.rst_state = RIP_FAULT;
      RIP_FAULT: if (!q.rst_s[1]) d.rst_state = RIP_HOLD;
      RIP_HOLD:  if (!(clock_fail_i | watchdog_fail_i)) d.rst_state = RIP_RUN;
      default:   d.rst_state = RIP_RUN;
    endcase
  end

  // All state in one register; asynchronous low reset restores startup values
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q           <= '0;
      q.pin_s1    <= 5'h1f;
      q.pin_s2    <= 5'h1f;
      q.pin_old   <= 5'h1f;
      q.irq_s     <= 2'h3;
      q.nonmaskable_request_pin_s    <= 2'h3;
      q.irq_old   <= 1'b1;
      q.rst_s     <= 2'h3;
      q.ctrl      <= `RIP_CTRL_RESET;
      q.edge_sel  <= `RIP_EDGE_RESET;
      q.rst_state <= RIP_RUN;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Reset pin is open drain; only drives low
  assign reset_pin_o    = 1'b0;
  assign reset_pin_oe_o = q.rst_state != RIP_RUN;
  // Synchronised low pin requests a full logic reset
  assign logic_reset_o  = ~q.rst_s[1];

  // Nonmaskable line: level, gated by its mask flag, retaken while low
  assign nonmaskable_request_pin_int_o = ~q.nonmaskable_request_pin_s[1] & ~q.ctrl[`RIP_CTRL_X_FLAG];
  // Maskable line: level or latched falling edge
  assign irq_int_o  = ~q.ctrl[`RIP_CTRL_I_FLAG] &
                      (q.ctrl[`RIP_CTRL_IRQ_EDGE] ? q.irq_pend : ~q.irq_s[1]);
  assign pin_int_o  = |(q.status & q.mask) & ~q.ctrl[`RIP_CTRL_I_FLAG];
  assign int_o      = |(q.status & q.mask);

  assign address_strobe_output_o = q.ctrl[`RIP_CTRL_SINGLE] ? 1'b0 : address_strobe_i;

  // Zero wait state APB slave, unmapped reads return zero
  assign apb_rsp_o.pready  = 1'b1;
  assign apb_rsp_o.pslverr = 1'b0;
  assign apb_rsp_o.prdata  = rd ? q.rdata : 32'h0000_0000;

  // Request line checks: masks, level and latched edge behaviour
  a_xflag_blocks: assert property (@(posedge clk_i) disable iff (!rstn_i)
    q.ctrl[`RIP_CTRL_X_FLAG] |-> !nonmaskable_request_pin_int_o)
    else $error("nonmaskable passed mask");

  a_nonmaskable_request_pin_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!q.nonmaskable_request_pin_s[1] && !q.ctrl[`RIP_CTRL_X_FLAG]) |-> nonmaskable_request_pin_int_o)
    else $error("level missed");

  a_nonmaskable_request_pin_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    q.nonmaskable_request_pin_s[1] |-> !nonmaskable_request_pin_int_o)
    else $error("nonmaskable without low line");

  a_irq_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!q.ctrl[`RIP_CTRL_IRQ_EDGE] && !q.ctrl[`RIP_CTRL_I_FLAG] && !q.irq_s[1]) |-> irq_int_o)
    else $error("irq level missed");

  a_irq_level_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!q.ctrl[`RIP_CTRL_IRQ_EDGE] && q.irq_s[1]) |-> !irq_int_o)
    else $error("irq without low line");

  a_irq_imask: assert property (@(posedge clk_i) disable iff (!rstn_i)
    q.ctrl[`RIP_CTRL_I_FLAG] |-> !irq_int_o)
    else $error("irq passed mask");

  a_irq_latch_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && irq_edge_ev) |=> q.irq_pend)
    else $error("falling edge not latched");

  a_irq_latch_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && wr_ctrl && !irq_edge_ev) |=> !q.irq_pend)
    else $error("edge latch not cleared");

  a_irq_latch_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && !wr_ctrl && q.irq_pend) |=> q.irq_pend)
    else $error("edge latch lost");

  a_irq_edge_out: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (q.ctrl[`RIP_CTRL_IRQ_EDGE] && !q.ctrl[`RIP_CTRL_I_FLAG] && q.irq_pend) |-> irq_int_o)
    else $error("latched edge not raised");

  a_irq_edge_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (q.ctrl[`RIP_CTRL_IRQ_EDGE] && !q.irq_pend) |-> !irq_int_o)
    else $error("edge mode raised without edge");

  // Register writes land once and otherwise hold
  a_ctrl_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && wr_ctrl) |=> q.ctrl == $past(apb_req_i.pwdata[3:0]))
    else $error("ctrl write lost");

  a_ctrl_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && !wr_ctrl) |=> $stable(q.ctrl))
    else $error("ctrl changed unasked");

  a_mask_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && wr_mask) |=> q.mask == $past(apb_req_i.pwdata[4:0]))
    else $error("mask write lost");

  a_mask_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && !wr_mask) |=> $stable(q.mask))
    else $error("mask changed unasked");

  a_edge_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && wr_edge) |=> q.edge_sel == $past(apb_req_i.pwdata[9:0]))
    else $error("edge select write lost");

  a_edge_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && !wr_edge) |=> $stable(q.edge_sel))
    else $error("edge select changed unasked");

  // Status flags: sticky, cleared only by software, readable
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && |hit) |=> (q.status & $past(hit)) == $past(hit))
    else $error("event lost");

  a_status_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && wr_status && hit == 5'h00) |=> (q.status & $past(apb_req_i.pwdata[4:0])) == 5'h00)
    else $error("status not cleared");

  a_status_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && !wr_status && hit == 5'h00) |=> $stable(q.status))
    else $error("status changed unasked");

  a_status_freeze: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ce_i |=> $stable(q.status))
    else $error("status moved while frozen");

  a_status_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && apb_req_i.paddr == `RIP_ADDR_STATUS) |=> q.rdata[4:0] == $past(q.status))
    else $error("status readback wrong");

  a_rdata_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !acc |-> apb_rsp_o.prdata == 32'h0000_0000)
    else $error("read data outside access");

  // Pin events: synchronised, qualified per pin, each seen once
  a_sync_chain: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i |=> q.pin_s2 == $past(q.pin_s1))
    else $error("synchroniser skipped");

  a_rise_once: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && rise != 5'h00) |=> (rise & $past(rise)) == 5'h00)
    else $error("rise seen twice");

  a_fall_once: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && fall != 5'h00) |=> (fall & $past(fall)) == 5'h00)
    else $error("fall seen twice");

  a_hit_needs_edge: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (hit & ~(rise | fall)) == 5'h00)
    else $error("event without edge");

  a_pai_one_edge: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (q.edge_sel[2*`RIP_PAI_BIT +: 2] == `RIP_EDGE_BOTH) |-> !(fall[`RIP_PAI_BIT] && hit[`RIP_PAI_BIT]))
    else $error("accumulator took both edges");

  a_strobe_a_input_one_edge: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (q.edge_sel[2*`RIP_STROBE_A_INPUT_BIT +: 2] == `RIP_EDGE_BOTH) |-> !(fall[`RIP_STROBE_A_INPUT_BIT] && hit[`RIP_STROBE_A_INPUT_BIT]))
    else $error("strobe took both edges");

  a_strobe_a_input_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !q.ctrl[`RIP_CTRL_SINGLE] |-> !hit[`RIP_STROBE_A_INPUT_BIT])
    else $error("strobe in expanded");

  a_as_single: assert property (@(posedge clk_i) disable iff (!rstn_i)
    q.ctrl[`RIP_CTRL_SINGLE] |-> !address_strobe_output_o)
    else $error("address strobe in single-chip");

  a_as_expanded: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !q.ctrl[`RIP_CTRL_SINGLE] |-> address_strobe_output_o == address_strobe_i)
    else $error("address strobe lost");

  // Pin interrupt gating by local enable and global flag
  a_pin_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pin_int_o |-> (|(q.status & q.mask)) && !q.ctrl[`RIP_CTRL_I_FLAG])
    else $error("pin irq ungated");

  a_pin_unmasked: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ((q.status & q.mask) != 5'h00 && !q.ctrl[`RIP_CTRL_I_FLAG]) |-> pin_int_o)
    else $error("pin irq missed");

  a_pin_local: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ((q.status & q.mask) == 5'h00) |-> (!pin_int_o && !int_o))
    else $error("pin irq without enabled flag");

  // Reset pin: failures pull it low, a low pin resets the logic
  a_fault_drive: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && q.rst_state == RIP_RUN && watchdog_fail_i) |=> reset_pin_oe_o)
    else $error("failure not driven");

  a_clock_fault: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && q.rst_state == RIP_RUN && clock_fail_i) |=> reset_pin_oe_o)
    else $error("clock failure not driven");

  a_fault_stays: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && q.rst_state != RIP_RUN && (clock_fail_i || watchdog_fail_i)) |=> reset_pin_oe_o)
    else $error("pin released during failure");

  a_open_drain: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reset_pin_oe_o |-> !reset_pin_o)
    else $error("reset pin driven high");

  a_reset_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (ce_i && !reset_pin_i) ##1 (ce_i && !reset_pin_i) |=> logic_reset_o)
    else $error("reset not seen");
endmodule : rip_top

// ===== sim/rip_src_model.sv
// External request sources and reset supervisor on open-drain lines
`timescale 1ns/1ps
module rip_src_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] raise_i,
  input  wire logic [1:0] ack_i,
  input  wire logic       nonmaskable_request_pin_raise_i,
  input  wire logic       sup_low_i,
  input  wire logic       dev_oe_i,
  output logic            irq_line_o,
  output logic            nonmaskable_request_pin_line_o,
  output logic            reset_line_o
);
  logic [1:0] pend_q = 2'h0;
  // A source keeps pulling until it is acknowledged
  always @(posedge clk_i) begin
    pend_q <= (pend_q | raise_i) & ~ack_i;
  end
  // Pull-ups win when nobody pulls, so a released line reads high
  assign irq_line_o   = ~|pend_q;
  assign nonmaskable_request_pin_line_o  = ~nonmaskable_request_pin_raise_i;
  assign reset_line_o = ~(sup_low_i | dev_oe_i);
endmodule : rip_src_model

// ===== sim/tb_top.sv
// Self-checking bench for the reset and interrupt pin block
`timescale 1ns/1ps
`include "rip_cfg.svh"
module tb_top;
  import rip_pkg::*;
  logic            clk = 0, rstn = 0, xr = 0, sup = 0, as_in = 0;
  logic [1:0]      rs = 0, ak = 0, fail = 0;
  logic [4:0]      pv = 0;
  logic            irq_l, nonmaskable_request_pin_l, rst_l, oe, lrst, ao, xi, ii, pi, io;
  rip_apb_req_type req = '0;
  rip_apb_rsp_type rsp;
  logic [31:0]     q[$];
  int              miscompares = 0, check_count = 0, seed = 32'h2a608571, m;
  always #2.5 clk = ~clk;
  rip_top rip_top_inst (.clk_i(clk), .rstn_i(rstn), .ce_i(1'b1), .apb_req_i(req),
    .apb_rsp_o(rsp), .reset_pin_i(rst_l), .reset_pin_o(), .reset_pin_oe_o(oe),
    .clock_fail_i(fail[0]), .watchdog_fail_i(fail[1]), .nonmaskable_request_pin_i(nonmaskable_request_pin_l),
    .irq_pin_i(irq_l), .capture_input_1_i(pv[2]), .capture_input_2_i(pv[1]),
    .capture_input_3_i(pv[0]), .pulse_accumulator_input_i(pv[3]), .strobe_a_input_i(pv[4]),
    .address_strobe_i(as_in), .address_strobe_output_o(ao), .logic_reset_o(lrst),
    .nonmaskable_request_pin_int_o(xi), .irq_int_o(ii), .pin_int_o(pi), .int_o(io));
  rip_src_model rip_src_model_inst (.clk_i(clk), .raise_i(rs), .ack_i(ak),
    .nonmaskable_request_pin_raise_i(xr), .sup_low_i(sup), .dev_oe_i(oe), .irq_line_o(irq_l),
    .nonmaskable_request_pin_line_o(nonmaskable_request_pin_l), .reset_line_o(rst_l));
  task automatic check(logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic w(int n);
    repeat (n) @(posedge clk);
  endtask : w
  // Setup cycle, then access until pready; the bound stops a hung slave
  task automatic xfer(logic wr_en, logic [11:0] a, logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr_en, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 20) begin
      miscompares++;
      summarize();
    end
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer
  task automatic wr(logic [11:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
    w(2);
  endtask : wr
  task automatic rd(logic [11:0] a, logic [31:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic pulse_src(logic [1:0] r, logic [1:0] k);
    rs <= r;
    ak <= k;
    @(posedge clk);
    rs <= 2'h0;
    ak <= 2'h0;
    w(6);
  endtask : pulse_src
  // Read data is judged at the completing edge, oldest note first
  always @(posedge clk) begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1 && q.size() > 0)
      check(rsp.prdata, q.pop_front());
  end
  initial begin
    w(16);
    rstn <= 1'b1;
    rd(`RIP_ADDR_CTRL, 32'he);
    rd(12'h100, 32'h0);
    $display("test reset done");
    // Random edge choice per pin; both directions tried on each
    for (int i = 0; i < 5; i++) begin
      m = 1 + $unsigned($random(seed)) % ((i < 3) ? 3 : 2);
      wr(`RIP_ADDR_EDGE, 32'(m << (2 * i)));
      pv[i] <= 1'b1;
      w(6);
      rd(`RIP_ADDR_STATUS, 32'((m & 1) << i));
      wr(`RIP_ADDR_STATUS, 32'h1f);
      pv[i] <= 1'b0;
      w(6);
      rd(`RIP_ADDR_STATUS, 32'(((m >> 1) & 1) << i));
      wr(`RIP_ADDR_STATUS, 32'h1f);
    end
    $display("test pin edges done");
    wr(`RIP_ADDR_CTRL, 32'h6);
    wr(`RIP_ADDR_EDGE, 32'h100);
    as_in <= 1'b1;
    pv[4] <= 1'b1;
    w(6);
    check(ao, 1'b1);
    rd(`RIP_ADDR_STATUS, 32'h0);
    pv[4] <= 1'b0;
    wr(`RIP_ADDR_CTRL, 32'hc);
    check(ao, 1'b0);
    as_in <= 1'b0;
    wr(`RIP_ADDR_EDGE, 32'h1);
    wr(`RIP_ADDR_MASK, 32'h1);
    pv[0] <= 1'b1;
    w(6);
    check(pi, 1'b0);
    check(io, 1'b1);
    wr(`RIP_ADDR_CTRL, 32'h8);
    check(pi, 1'b1);
    wr(`RIP_ADDR_STATUS, 32'h1);
    check(pi, 1'b0);
    $display("test gating done");
    xr <= 1'b1;
    pulse_src(2'h3, 2'h0);
    check(xi, 1'b1);
    check(ii, 1'b1);
    pulse_src(2'h0, 2'h1);
    check(ii, 1'b1);
    pulse_src(2'h0, 2'h2);
    check(ii, 1'b0);
    wr(`RIP_ADDR_CTRL, 32'ha);
    check(xi, 1'b0);
    xr <= 1'b0;
    wr(`RIP_ADDR_CTRL, 32'h9);
    pulse_src(2'h1, 2'h0);
    pulse_src(2'h0, 2'h1);
    check(ii, 1'b1);
    wr(`RIP_ADDR_CTRL, 32'h9);
    check(ii, 1'b0);
    $display("test request pins done");
    for (int f = 0; f < 2; f++) begin
      fail <= 2'(1 << f);
      w(3);
      check(oe, 1'b1);
      fail <= 2'h0;
      w(8);
      check(oe, 1'b0);
    end
    sup <= 1'b1;
    w(4);
    check(lrst, 1'b1);
    sup <= 1'b0;
    w(4);
    check(lrst, 1'b0);
    $display("test reset pin done");
    summarize();
  end
endmodule : tb_top
